/* src/mcf_common_flags_regs.vh */
// Constants of the motion common-flag block
`ifndef MCF_COMMON_FLAGS_REGS_VH
`define MCF_COMMON_FLAGS_REGS_VH
// Axis count of the largest variant
`define MCF_AXES 32
// Axis range select codes
`define MCF_LIMIT_32 2'h0
`define MCF_LIMIT_16 2'h1
`define MCF_LIMIT_8 2'h2
// Ready source modes
`define MCF_SRC_SWITCH 1'h0
`define MCF_SRC_SETTING 1'h1
// Reset values
`define MCF_RST_FLAGS 32'h00000000
`define MCF_RST_BIT 1'h0
// Auxiliary-code handshake states
`define MCF_AUX_IDLE 2'h0
`define MCF_AUX_WAIT_HI 2'h1
`define MCF_AUX_WAIT_LO 2'h2
// Cycles after reset release before the fitted-module compare
`define MCF_CHECK_DELAY 2'h3
`endif

/* src/mcf_common_flags.v */
// Common command and status flags of a multi-axis motion processor
`timescale 1ns/1ps
`include "mcf_common_flags_regs.vh"
// Behaviour
// - Motion only while host-ready flag is on
// - Test mode blocks all motion control
// - Parameter writes accepted only while ready off
// - Ready rise: clear aux codes, set done, restart
// - Axis starting at ready rise: error, skip
// - Ready rise in test mode deferred until end
// - Ready fall: clear done, decelerate, halt, outputs off
// - Default mode: ready follows run/stop switch
// - Alternate mode: setting/alt flag rise sets ready
// - Alternate mode: fall or stop clears ready
// - One start flag per axis, 32/16/8 range
// - Program start sets flags; completion/stop clears, except stop by zero speed
// - Jog command sets flag; off and stopped clears
// - Handwheel enable sets flag; removal clears
// - Current value change holds flag until done
// - Forced-on flag makes next start error
// - History clear request erases, then self-clears
// - Debug flag follows sequence debug mode
// - Speed-switch option latched at constant-speed start
// - Compare configuration with fitted modules after reset
// - Setting error refuses program starts and current value changes; jog and handwheel still set flags
// - Aux handshake only with finish-type acceleration
// - No flag retained across power loss
// - Ack rise drops aux flag; fall starts block
module mcf_common_flags (
    input wire clk,
    input wire arst_n,
    input wire runSwitch,
    input wire readySourceMode,
    input wire readySettingBit,
    input wire alternateReadyFlag,
    input wire testModeFlag,
    input wire [1:0] axisLimit,
    input wire paramWriteReq,
    input wire programStartInstr,
    input wire [31:0] startAxisMask,
    input wire [31:0] positioningDone,
    input wire [31:0] stopMidway,
    input wire [31:0] stopBySpeedZero,
    input wire [31:0] jogForwardCommand,
    input wire [31:0] jogReverseCommand,
    input wire [31:0] axisStopped,
    input wire [31:0] handwheelEnable,
    input wire currentValueChangeInstr,
    input wire [31:0] changeAxisMask,
    input wire [31:0] changeDone,
    input wire [31:0] forceStartAccept,
    input wire historyClearWrite,
    input wire debugModeActive,
    input wire speedSwitchPointOption,
    input wire constantSpeedStart,
    input wire [7:0] storedConfig,
    input wire [7:0] fittedModules,
    input wire finishAccelSelected,
    input wire auxCodeIssue,
    input wire blockFinishAck,
    output wire hostReadyFlag,
    output wire motionEnable,
    output wire motionReadyDone,
    output wire clearAuxCodes,
    output wire seqRestart,
    output wire seqHalt,
    output wire realOutputsOff,
    output wire [31:0] decelStopMask,
    output wire readyStartingError,
    output wire paramWriteAccept,
    output wire paramWriteRefused,
    output wire [31:0] startAcceptedFlags,
    output wire startAcceptOnError,
    output wire startRefused,
    output wire historyClearRequest,
    output wire historyErase,
    output wire debugModeFlag,
    output wire speedFromFirstPoint,
    output wire settingErrorFlag,
    output wire auxCodeOutputFlag,
    output wire nextBlockGo
);

    // Valid-axis mask for the fitted variant; used by every flag path
    function [31:0] axisRange;
        input [1:0] lim;
        begin
            case (lim)
                `MCF_LIMIT_16: axisRange = 32'h0000ffff;
                `MCF_LIMIT_8: axisRange = 32'h000000ff;
                default: axisRange = 32'hffffffff;
            endcase
        end
    endfunction

    // Run switch is a pin: two-stage synchroniser, then previous level for edges
    reg runMeta_reg, runSync_reg, runPrev_reg;
    // Previous levels of the ready sources
    reg setBitPrev_reg, altPrev_reg, testPrev_reg;
    // Host-ready state and its edge memory
    reg hostReady_reg, hostReady_next, readyPrev_reg;
    reg risePending_reg; // Rise seen during test mode
    // Ready-edge effects
    reg readyDone_reg, clearAux_reg, seqRestart_reg, seqHalt_reg, outputsOff_reg, readyErr_reg;
    reg [31:0] decel_reg; // One-cycle stop mask
    // Parameter write answers
    reg paramAcc_reg, paramRef_reg;
    // Start-accepted flags and ownership of jog/handwheel
    reg [31:0] startAcc_reg, startAcc_next, jogOwn_reg, jogOwn_next, wheelPrev_reg;
    reg [31:0] forced_reg, forced_next; // Flags set from outside
    reg startErr_reg, startRef_reg;
    // History clear
    reg histReq_reg, histPrev_reg, histErase_reg;
    // Debug, speed option, setting check
    reg debug_reg, speedFirst_reg, settingErr_reg;
    reg [1:0] checkCnt_reg; // Cycles since reset release
    // Aux-code handshake
    reg [1:0] auxState_reg, auxState_next;
    reg auxFlag_reg, auxFlag_next, nextGo_reg, nextGo_next;

    wire [31:0] validAxes = axisRange(axisLimit);
    wire runRise = runSync_reg & ~runPrev_reg;
    wire runFall = ~runSync_reg & runPrev_reg;
    wire readyRise = hostReady_reg & ~readyPrev_reg;
    wire readyFall = ~hostReady_reg & readyPrev_reg;
    wire testEnd = ~testModeFlag & testPrev_reg;
    // Motion permitted only with ready on and test mode off
    wire canMove = hostReady_reg & ~testModeFlag;
    // Starts refused on setting error or without permission
    wire startOk = canMove & ~settingErr_reg;
    wire [31:0] startReq = programStartInstr ? (startAxisMask & validAxes) : 32'h00000000;
    // A start hitting a flag already on, forced or not, is an error
    wire startClash = |(startReq & startAcc_reg);
    wire startGo = programStartInstr & startOk & ~startClash;
    wire chgaGo = currentValueChangeInstr & startOk;
    wire [31:0] jogOn = (jogForwardCommand | jogReverseCommand) & validAxes;
    // Rising-edge processing runs now, or later once test mode ends
    wire riseNow = readyRise & ~testModeFlag;
    wire riseLate = risePending_reg & testEnd & hostReady_reg;
    wire riseAct = riseNow | riseLate;
    wire riseBad = riseAct & (|startAcc_reg);

    // Ready source selection
    always @* begin
        hostReady_next = hostReady_reg;
        if (readySourceMode == `MCF_SRC_SWITCH) begin
            // Level follow covers power-up in run as well
            hostReady_next = runSync_reg;
        end else begin
            if (runSync_reg && ((readySettingBit && !setBitPrev_reg) ||
                (alternateReadyFlag && !altPrev_reg))) begin
                hostReady_next = 1'h1;
            end
            if ((!readySettingBit && setBitPrev_reg) ||
                (!alternateReadyFlag && altPrev_reg) || runFall || !runSync_reg) begin
                hostReady_next = 1'h0;
            end
        end
    end

    // Start-accepted flag next state; sets win over clears
    always @* begin : flagCalc
        integer i;
        startAcc_next = startAcc_reg;
        jogOwn_next = jogOwn_reg;
        forced_next = forced_reg & startAcc_reg;
        for (i = 0; i < `MCF_AXES; i = i + 1) begin
            // Clear paths first
            if (positioningDone[i] || (stopMidway[i] && !stopBySpeedZero[i]))
                startAcc_next[i] = 1'h0;
            if (jogOwn_reg[i] && !jogOn[i] && axisStopped[i]) begin
                startAcc_next[i] = 1'h0;
                jogOwn_next[i] = 1'h0;
            end
            if (wheelPrev_reg[i] && !handwheelEnable[i])
                startAcc_next[i] = 1'h0;
            if (changeDone[i])
                startAcc_next[i] = 1'h0;
            // Set paths
            if (startGo && startReq[i])
                startAcc_next[i] = 1'h1;
            if (jogOn[i] && canMove) begin
                startAcc_next[i] = 1'h1;
                jogOwn_next[i] = 1'h1;
            end
            if (handwheelEnable[i] && validAxes[i] && canMove)
                startAcc_next[i] = 1'h1;
            if (chgaGo && changeAxisMask[i] && validAxes[i])
                startAcc_next[i] = 1'h1;
            // Outside write on an idle flag poisons the next start
            if (forceStartAccept[i] && !startAcc_reg[i] && validAxes[i]) begin
                startAcc_next[i] = 1'h1;
                forced_next[i] = 1'h1;
            end
        end
        startAcc_next = startAcc_next & validAxes;
    end

    // Aux-code handshake state machine
    always @* begin
        auxState_next = auxState_reg;
        auxFlag_next = auxFlag_reg;
        nextGo_next = 1'h0;
        case (auxState_reg)
            `MCF_AUX_IDLE: begin
                // Without finish-type acceleration the wait is skipped
                if (auxCodeIssue && finishAccelSelected) begin
                    auxState_next = `MCF_AUX_WAIT_HI;
                    auxFlag_next = 1'h1;
                end else if (auxCodeIssue) begin
                    nextGo_next = 1'h1;
                end
            end
            `MCF_AUX_WAIT_HI: begin
                if (blockFinishAck) begin
                    auxState_next = `MCF_AUX_WAIT_LO;
                    auxFlag_next = 1'h0;
                end
            end
            `MCF_AUX_WAIT_LO: begin
                if (!blockFinishAck) begin
                    auxState_next = `MCF_AUX_IDLE;
                    nextGo_next = 1'h1;
                end
            end
            default: begin
                auxState_next = `MCF_AUX_IDLE;
                auxFlag_next = 1'h0;
            end
        endcase
        // Ready loss abandons any pending block
        if (readyFall) begin
            auxState_next = `MCF_AUX_IDLE;
            auxFlag_next = 1'h0;
        end
    end

    // All state; nothing here survives reset or power loss
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            runMeta_reg <= `MCF_RST_BIT;
            runSync_reg <= `MCF_RST_BIT;
            runPrev_reg <= `MCF_RST_BIT;
            setBitPrev_reg <= `MCF_RST_BIT;
            altPrev_reg <= `MCF_RST_BIT;
            testPrev_reg <= `MCF_RST_BIT;
            hostReady_reg <= `MCF_RST_BIT;
            readyPrev_reg <= `MCF_RST_BIT;
            risePending_reg <= `MCF_RST_BIT;
            readyDone_reg <= `MCF_RST_BIT;
            clearAux_reg <= `MCF_RST_BIT;
            seqRestart_reg <= `MCF_RST_BIT;
            seqHalt_reg <= `MCF_RST_BIT;
            outputsOff_reg <= `MCF_RST_BIT;
            decel_reg <= `MCF_RST_FLAGS;
            readyErr_reg <= `MCF_RST_BIT;
            paramAcc_reg <= `MCF_RST_BIT;
            paramRef_reg <= `MCF_RST_BIT;
            startAcc_reg <= `MCF_RST_FLAGS;
            jogOwn_reg <= `MCF_RST_FLAGS;
            wheelPrev_reg <= `MCF_RST_FLAGS;
            forced_reg <= `MCF_RST_FLAGS;
            startErr_reg <= `MCF_RST_BIT;
            startRef_reg <= `MCF_RST_BIT;
            histReq_reg <= `MCF_RST_BIT;
            histPrev_reg <= `MCF_RST_BIT;
            histErase_reg <= `MCF_RST_BIT;
            debug_reg <= `MCF_RST_BIT;
            speedFirst_reg <= `MCF_RST_BIT;
            settingErr_reg <= `MCF_RST_BIT;
            checkCnt_reg <= 2'h0;
            auxState_reg <= `MCF_AUX_IDLE;
            auxFlag_reg <= `MCF_RST_BIT;
            nextGo_reg <= `MCF_RST_BIT;
        end else begin
            // Synchroniser: first stage read only by the second
            runMeta_reg <= runSwitch;
            runSync_reg <= runMeta_reg;
            runPrev_reg <= runSync_reg;
            setBitPrev_reg <= readySettingBit;
            altPrev_reg <= alternateReadyFlag;
            testPrev_reg <= testModeFlag;
            hostReady_reg <= hostReady_next;
            readyPrev_reg <= hostReady_reg;
            // Deferred rise remembered until test mode ends
            if (readyRise && testModeFlag) begin
                risePending_reg <= 1'h1;
            end else if (testEnd || readyFall) begin
                risePending_reg <= 1'h0;
            end
            // Rising-edge processing, skipped on a starting axis
            clearAux_reg <= riseAct & ~riseBad;
            seqRestart_reg <= riseAct & ~riseBad;
            readyErr_reg <= riseBad;
            if (readyFall) begin
                readyDone_reg <= 1'h0;
            end else if (riseAct && !riseBad) begin
                readyDone_reg <= 1'h1;
            end
            // Falling-edge processing
            seqHalt_reg <= readyFall;
            decel_reg <= readyFall ? startAcc_reg : 32'h00000000;
            if (readyFall) begin
                outputsOff_reg <= 1'h1;
            end else if (riseAct && !riseBad) begin
                outputsOff_reg <= 1'h0;
            end
            // Fixed-data writes only while ready is off
            paramAcc_reg <= paramWriteReq & ~hostReady_reg;
            paramRef_reg <= paramWriteReq & hostReady_reg;
            startAcc_reg <= startAcc_next;
            jogOwn_reg <= jogOwn_next;
            wheelPrev_reg <= handwheelEnable & validAxes;
            forced_reg <= forced_next;
            startErr_reg <= programStartInstr & startClash;
            startRef_reg <= programStartInstr & ~startGo;
            // Request self-clears after erase; a new write wins
            if (historyClearWrite) begin
                histReq_reg <= 1'h1;
            end else if (histErase_reg) begin
                histReq_reg <= 1'h0;
            end
            histPrev_reg <= histReq_reg;
            histErase_reg <= histReq_reg & ~histPrev_reg;
            debug_reg <= debugModeActive;
            // Option sampled only when a constant-speed run begins
            if (constantSpeedStart) begin
                speedFirst_reg <= speedSwitchPointOption;
            end
            // One compare after reset release, held until next reset
            if (checkCnt_reg != `MCF_CHECK_DELAY) begin
                checkCnt_reg <= checkCnt_reg + 2'h1;
                if (checkCnt_reg == `MCF_CHECK_DELAY - 2'h1) begin
                    settingErr_reg <= (storedConfig != fittedModules);
                end
            end
            auxState_reg <= auxState_next;
            auxFlag_reg <= auxFlag_next;
            nextGo_reg <= nextGo_next;
        end
    end

    // Outputs straight from flip-flops
    assign hostReadyFlag = hostReady_reg;
    assign motionEnable = readyDone_reg;
    assign motionReadyDone = readyDone_reg;
    assign clearAuxCodes = clearAux_reg;
    assign seqRestart = seqRestart_reg;
    assign seqHalt = seqHalt_reg;
    assign realOutputsOff = outputsOff_reg;
    assign decelStopMask = decel_reg;
    assign readyStartingError = readyErr_reg;
    assign paramWriteAccept = paramAcc_reg;
    assign paramWriteRefused = paramRef_reg;
    assign startAcceptedFlags = startAcc_reg;
    assign startAcceptOnError = startErr_reg;
    assign startRefused = startRef_reg;
    assign historyClearRequest = histReq_reg;
    assign historyErase = histErase_reg;
    assign debugModeFlag = debug_reg;
    assign speedFromFirstPoint = speedFirst_reg;
    assign settingErrorFlag = settingErr_reg;
    assign auxCodeOutputFlag = auxFlag_reg;
    assign nextBlockGo = nextGo_reg;

endmodule

/* verification/mcf_common_flags_chk.sv */
// Port-level assertions of the motion common-flag block
`timescale 1ns/1ps
module mcf_common_flags_chk (
    input wire clk,
    input wire arst_n,
    input wire testModeFlag,
    input wire paramWriteReq,
    input wire programStartInstr,
    input wire finishAccelSelected,
    input wire auxCodeIssue,
    input wire blockFinishAck,
    input wire hostReadyFlag,
    input wire motionReadyDone,
    input wire clearAuxCodes,
    input wire seqRestart,
    input wire seqHalt,
    input wire realOutputsOff,
    input wire readyStartingError,
    input wire paramWriteAccept,
    input wire paramWriteRefused,
    input wire [31:0] startAcceptedFlags,
    input wire startRefused,
    input wire historyClearRequest,
    input wire historyErase,
    input wire settingErrorFlag,
    input wire auxCodeOutputFlag,
    input wire nextBlockGo
);
    // Single domain, so one clock and one reset for all
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Clean ready rise runs the restart set one cycle later
    chk_ready_rise_done: assert property (
        $rose(hostReadyFlag) && !testModeFlag && startAcceptedFlags == 32'h0
        |=> motionReadyDone && seqRestart && clearAuxCodes) else $error("ready rise not processed");
    // Busy axis at ready rise skips the restart and flags an error
    chk_ready_busy_err: assert property (
        $rose(hostReadyFlag) && !testModeFlag && startAcceptedFlags != 32'h0
        |=> readyStartingError && !seqRestart) else $error("busy rise not refused");
    // Ready fall halts, clears done and turns outputs off
    chk_ready_fall_halt: assert property (
        $fell(hostReadyFlag) |=> seqHalt && !motionReadyDone && realOutputsOff)
        else $error("ready fall not processed");
    // Done never stands without ready one cycle before
    chk_done_needs_ready: assert property (
        motionReadyDone |-> $past(hostReadyFlag)) else $error("done without ready");
    // Parameter writes refused while ready is on
    chk_param_refused: assert property (
        paramWriteReq && hostReadyFlag |=> paramWriteRefused && !paramWriteAccept)
        else $error("write not refused");
    // Parameter writes accepted while ready is off
    chk_param_accept: assert property (
        paramWriteReq && !hostReadyFlag |=> paramWriteAccept && !paramWriteRefused)
        else $error("write not accepted");
    // Starts refused in test mode
    chk_test_no_start: assert property (
        programStartInstr && testModeFlag |=> startRefused) else $error("test start ran");
    // Starts refused under a setting error
    chk_setting_refuse: assert property (
        programStartInstr && settingErrorFlag |=> startRefused) else $error("start ran");
    // Request erases once, then clears itself
    chk_history_self: assert property (
        $rose(historyClearRequest) |=> historyErase ##1 !historyClearRequest)
        else $error("history request stuck");
    // Without finish acceleration the code flag stays off
    chk_aux_no_finish: assert property (
        auxCodeIssue && !finishAccelSelected |=> nextBlockGo && !auxCodeOutputFlag)
        else $error("aux flag without finish mode");
    // Acknowledge drops the code flag in the next cycle
    chk_aux_ack_drop: assert property (
        auxCodeOutputFlag && blockFinishAck |=> !auxCodeOutputFlag) else $error("aux flag held");
endmodule
bind mcf_common_flags mcf_common_flags_chk mcf_common_flags_chk_inst (.*);

/* verification/mcf_host_model.sv */
// Host logic model answering the auxiliary-code handshake
`timescale 1ns/1ps
module mcf_host_model (
    input wire clk,
    input wire arst_n,
    input wire auxCodeOutputFlag,
    input wire [3:0] ackDelay,
    output logic blockFinishAck
);
    logic [3:0] waitCnt; // Cycles spent before acknowledging
    // Ack after a chosen delay, held until the code flag drops
    always @(negedge clk or negedge arst_n) begin
        if (!arst_n) begin
            blockFinishAck <= 1'b0;
            waitCnt <= 4'h0;
        end else if (!blockFinishAck && auxCodeOutputFlag) begin
            // Slow hosts are modelled by a longer delay
            if (waitCnt == ackDelay) begin
                blockFinishAck <= 1'b1;
                waitCnt <= 4'h0;
            end else begin
                waitCnt <= waitCnt + 4'h1;
            end
        end else if (blockFinishAck && !auxCodeOutputFlag) begin
            blockFinishAck <= 1'b0;
        end
    end
endmodule

/* verification/test_mcf_common_flags.sv */
// Self-checking bench of the motion common-flag block
`timescale 1ns/1ps
`include "mcf_common_flags_regs.vh"
`define CK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
`define WT(c) begin for (int k = 0; k < 40 && !(c); k++) @(negedge clk); \
    if (!(c)) begin num_errors++; end_sim; end end
module test_mcf_common_flags;
    logic clk, arst_n, runSwitch, readySourceMode, readySettingBit, alternateReadyFlag;
    logic testModeFlag, paramWriteReq, programStartInstr, currentValueChangeInstr;
    logic historyClearWrite, debugModeActive, speedSwitchPointOption, constantSpeedStart;
    logic finishAccelSelected, auxCodeIssue, blockFinishAck;
    logic [1:0] axisLimit;
    logic [31:0] startAxisMask, positioningDone, stopMidway, stopBySpeedZero, axisStopped;
    logic [31:0] jogForwardCommand, jogReverseCommand, handwheelEnable, changeAxisMask;
    logic [31:0] changeDone, forceStartAccept, decelStopMask, startAcceptedFlags, expFlags, m;
    logic [7:0] storedConfig, fittedModules;
    logic [3:0] ackDelay; // Host answer delay
    logic hostReadyFlag, motionEnable, motionReadyDone, clearAuxCodes, seqRestart, seqHalt;
    logic realOutputsOff, readyStartingError, paramWriteAccept, paramWriteRefused;
    logic startAcceptOnError, startRefused, historyClearRequest, historyErase, debugModeFlag;
    logic speedFromFirstPoint, settingErrorFlag, auxCodeOutputFlag, nextBlockGo;
    int seed, num_errors, check_count;
    mcf_common_flags mcf_common_flags_inst (.*);
    mcf_host_model mcf_host_model_inst (.*);
    // 40 MHz clock
    always #12.5 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Verdict and end of run
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Program start against the bench's own flag model
    task automatic start(input logic [31:0] a);
        logic [31:0] lim;
        logic ok, clash;
        lim = axisLimit == `MCF_LIMIT_8 ? 32'hff : axisLimit == `MCF_LIMIT_16 ? 32'hffff : '1;
        clash = |(a & expFlags);
        ok = hostReadyFlag && !testModeFlag && !settingErrorFlag && !clash;
        startAxisMask = a;
        programStartInstr = 1'b1;
        cyc(1);
        programStartInstr = 1'b0;
        if (ok) expFlags = expFlags | (a & lim);
        `CK({startRefused, startAcceptOnError}, {!ok, clash})
        `CK(startAcceptedFlags, expFlags)
    endtask
    // Completion, stop part-way and stop by zero speed
    task automatic stopAx(input logic [31:0] d, s, z);
        {positioningDone, stopMidway, stopBySpeedZero} = {d, s, z};
        cyc(1);
        {positioningDone, stopMidway, stopBySpeedZero} = '0;
        cyc(1);
        expFlags = expFlags & ~(d | (s & ~z));
        `CK(startAcceptedFlags, expFlags)
    endtask
    task automatic paramW;
        paramWriteReq = 1'b1;
        cyc(1);
        paramWriteReq = 1'b0;
        `CK({paramWriteAccept, paramWriteRefused}, hostReadyFlag ? 2'h1 : 2'h2)
    endtask
    // Switch to run; busy selects the refused rise
    task automatic readyUp(input logic busy);
        runSwitch = 1'b1;
        `WT(hostReadyFlag === 1'b1)
        cyc(1);
        `CK({motionReadyDone, motionEnable, seqRestart, clearAuxCodes, readyStartingError},
            busy ? 5'h1 : 5'h1e)
    endtask
    task automatic readyDown;
        runSwitch = 1'b0;
        `WT(hostReadyFlag === 1'b0)
        cyc(1);
        `CK({motionReadyDone, seqHalt, realOutputsOff, decelStopMask}, {3'h3, expFlags})
    endtask
    initial begin
        {clk, arst_n, seed, num_errors, check_count, expFlags} = {2'h0, 32'd46007, 96'h0};
        {runSwitch, readySourceMode, readySettingBit, alternateReadyFlag, testModeFlag,
            paramWriteReq, programStartInstr, currentValueChangeInstr, historyClearWrite,
            debugModeActive, speedSwitchPointOption, constantSpeedStart, finishAccelSelected,
            auxCodeIssue, axisLimit, startAxisMask, positioningDone, stopMidway,
            stopBySpeedZero, axisStopped, jogForwardCommand, jogReverseCommand,
            handwheelEnable, changeAxisMask, changeDone, forceStartAccept} = '0;
        {storedConfig, fittedModules, ackDelay} = {16'h5a5a, 4'h2};
        cyc(2);
        `CK({hostReadyFlag, motionReadyDone, startAcceptedFlags}, 34'h0)
        arst_n = 1'b1;
        cyc(4);
        `CK(settingErrorFlag, 1'b0)
        start(32'h1);
        readyUp(1'b0);
        paramW();
        // Every axis range, random masks, clash on restart
        for (int i = 0; i < 3; i++) begin
            axisLimit = i[1:0];
            m = $random(seed) | 32'h1;
            start(m);
            start(m);
            stopAx(m & $random(seed), m, $random(seed));
            stopAx(m, '0, '0);
        end
        axisLimit = `MCF_LIMIT_32;
        // Outside write of a start flag poisons the next start
        forceStartAccept = 32'h4;
        cyc(1);
        forceStartAccept = '0;
        cyc(1);
        expFlags = 32'h4;
        start(32'h4);
        stopAx(32'h4, '0, '0);
        for (int j = 0; j < 2; j++) begin
            {jogReverseCommand[1], jogForwardCommand[1]} = 2'h1 << j;
            axisStopped = '0;
            cyc(2);
            `CK(startAcceptedFlags, 32'h2)
            {jogReverseCommand, jogForwardCommand} = '0;
            cyc(2);
            `CK(startAcceptedFlags, 32'h2)
            axisStopped = 32'h2;
            cyc(2);
            `CK(startAcceptedFlags, 32'h0)
        end
        handwheelEnable = 32'h8;
        cyc(2);
        `CK(startAcceptedFlags, 32'h8)
        {handwheelEnable, changeAxisMask, currentValueChangeInstr} = {32'h0, 32'h10, 1'b1};
        cyc(1);
        currentValueChangeInstr = 1'b0;
        cyc(1);
        `CK(startAcceptedFlags, 32'h10)
        changeDone = 32'h10;
        cyc(1);
        changeDone = '0;
        cyc(1);
        `CK(startAcceptedFlags, 32'h0)
        start(32'h1);
        readyDown();
        readyUp(1'b1);
        stopAx(32'h1, '0, '0);
        readyDown();
        paramW();
        // Rise inside test mode waits for its end
        testModeFlag = 1'b1;
        runSwitch = 1'b1;
        `WT(hostReadyFlag === 1'b1)
        cyc(2);
        `CK(motionReadyDone, 1'b0)
        start(32'h1);
        testModeFlag = 1'b0;
        cyc(2);
        `CK(motionReadyDone, 1'b1)
        readyDown();
        // Setting bit and alternate flag as ready source
        {readySourceMode, runSwitch} = 2'h3;
        cyc(5);
        for (int j = 0; j < 2; j++) begin
            {alternateReadyFlag, readySettingBit} = 2'h1 << j;
            cyc(2);
            `CK(hostReadyFlag, 1'b1)
            {alternateReadyFlag, readySettingBit} = 2'h0;
            cyc(2);
            `CK(hostReadyFlag, 1'b0)
        end
        alternateReadyFlag = 1'b1;
        cyc(2);
        {runSwitch, readySourceMode} = 2'h0;
        `WT(hostReadyFlag === 1'b0)
        historyClearWrite = 1'b1;
        cyc(1);
        historyClearWrite = 1'b0;
        `WT(historyErase === 1'b1)
        `CK(historyClearRequest, 1'b1)
        cyc(1);
        `CK({historyClearRequest, historyErase}, 2'h0)
        for (int j = 1; j >= 0; j--) begin
            {debugModeActive, speedSwitchPointOption, constantSpeedStart} = {j[0], j[0], 1'b1};
            cyc(1);
            constantSpeedStart = 1'b0;
            cyc(1);
            `CK({debugModeFlag, speedFromFirstPoint}, {j[0], j[0]})
        end
        // Code handshake with and without finish acceleration
        for (int j = 0; j < 2; j++) begin
            {finishAccelSelected, auxCodeIssue, ackDelay} = {j[0], 1'b1, 4'($random(seed))};
            cyc(1);
            auxCodeIssue = 1'b0;
            `WT(nextBlockGo === 1'b1)
            `CK({auxCodeOutputFlag, blockFinishAck}, 2'h0)
        end
        // Reset into a configuration mismatch
        {arst_n, fittedModules, expFlags} = {1'b0, 8'ha5, 32'h0};
        cyc(2);
        arst_n = 1'b1;
        cyc(4);
        `CK(settingErrorFlag, 1'b1)
        readyUp(1'b0);
        start(32'h1);
        end_sim();
    end
endmodule
